// File: core/fwp_map.vh
// Constants for the flash protection host controller
`ifndef FWP_MAP_VH
`define FWP_MAP_VH
// Timing figures in ns at a 4 ns clock
`define FWP_CLK_PERIOD_NS   4
`define FWP_GLITCH_NS       5
`define FWP_SETUP_NS        40
`define FWP_PULSE_NS        100
`define FWP_READ_NS         100
// Command codes
`define FWP_CMD_W           3
`define FWP_CMD_NOP         3'h0
`define FWP_CMD_WRITE       3'h1
`define FWP_CMD_READ        3'h2
`define FWP_CMD_PROTECT     3'h3
`define FWP_CMD_VERIFY      3'h4
`define FWP_CMD_UNPROTECT   3'h5
`define FWP_CMD_TEMP_ON     3'h6
`define FWP_CMD_TEMP_OFF    3'h7
// Address bit positions
`define FWP_ABIT0           0
`define FWP_ABIT1           1
`define FWP_ABIT6           6
`define FWP_ABIT9           9
// Data bit carrying the protect flag
`define FWP_PROT_BIT        0
`endif

// File: core/fwp_sync.v
// Two-flop synchroniser for pins entering the clock domain
`timescale 1ns/10ps
module fwp_sync #(
  parameter W = 8
) (
  input  wire         REF_CLK_IN,
  input  wire         SRST_IN,
  input  wire [W-1:0] d_in,
  output wire [W-1:0] q_out
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  always @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
    end else begin
      s1_r <= d_in;
      s2_r <= s1_r;
    end
  end
  assign q_out = s2_r;
endmodule // fwp_sync

// File: core/fwp_host.v
// Host controller driving a flash through its pins for writes and sector protection
//
// Function
// - The host starts a write by driving chip and write strobe low with output enable high.
// - While reset is held at the high-voltage level all sectors behave as unprotected.
// - Protecting a sector needs high voltage on address bit 9 and output enable over a write pulse.
// - Verify needs high voltage on bit 9, chip and output enable low, bit 1 high, bits 0 and 6 low.
// - Chip unprotect needs high voltage on output enable and bit 9, chip low, bit 6 high, a pulse.
// - The host should protect all sectors before starting chip unprotect; the code only needs one completed protect command.
`timescale 1ns/10ps
`include "fwp_map.vh"
module fwp_host #(
  parameter AW = 20,
  parameter DW = 8
) (
  input  wire                  REF_CLK_IN,
  input  wire                  SRST_IN,
  input  wire                  CMD_VALID_IN,
  input  wire [`FWP_CMD_W-1:0] CMD_CODE_IN,
  input  wire [AW-1:0]         CMD_ADDR_IN,
  input  wire [DW-1:0]         CMD_DATA_IN,
  output wire                  CMD_READY_OUT,
  output reg                   RSP_VALID_OUT,
  output reg  [DW-1:0]         RSP_DATA_OUT,
  output reg                   RSP_PROT_OUT,
  output reg                   TEMP_UNPROT_OUT,
  output reg                   CMD_REFUSED_OUT,
  output reg                   FL_CE_N_OUT,
  output reg                   FL_OE_N_OUT,
  output reg                   FL_WE_N_OUT,
  output reg  [AW-1:0]         FL_ADDR_OUT,
  output reg  [DW-1:0]         FL_DQ_OUT,
  output reg                   FL_DQ_OE_N_OUT,
  input  wire [DW-1:0]         FL_DQ_IN,
  output reg                   FL_HV_RESET_OUT,
  output reg                   FL_HV_OE_OUT,
  output reg                   FL_HV_A9_OUT
);
  // ****************************************
  // Timing counts
  // ****************************************
  localparam CW = 8;
  localparam integer  CP_NS      = `FWP_CLK_PERIOD_NS;
  localparam integer  GLITCH_I   = (`FWP_GLITCH_NS + CP_NS - 1) / CP_NS;
  localparam integer  SETUP_I    = (`FWP_SETUP_NS + CP_NS - 1) / CP_NS;
  localparam integer  PULSE_I    = (`FWP_PULSE_NS + CP_NS - 1) / CP_NS;
  localparam integer  READ_I     = (`FWP_READ_NS + CP_NS - 1) / CP_NS;
  localparam [CW-1:0] GLITCH_CYC = GLITCH_I[CW-1:0];
  localparam [CW-1:0] SETUP_CYC  = SETUP_I[CW-1:0];
  localparam [CW-1:0] PULSE_RAW  = PULSE_I[CW-1:0];
  localparam [CW-1:0] PULSE_CYC  = (PULSE_RAW > GLITCH_CYC) ? PULSE_RAW : GLITCH_CYC + 8'h01;
  localparam [CW-1:0] READ_CYC   = READ_I[CW-1:0];

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_SETUP = 3'h1;
  localparam [2:0] ST_PULSE = 3'h2;
  localparam [2:0] ST_READ  = 3'h3;
  localparam [2:0] ST_HOLD  = 3'h4;

  reg [2:0]            state_r;
  reg [2:0]            state_nxt;
  reg [CW-1:0]         cnt_r;
  reg [`FWP_CMD_W-1:0] op_r;
  reg                  all_prot_r;
  wire [DW-1:0]        dq_sync;

  fwp_sync #(.W(DW)) u_sync (
    .REF_CLK_IN (REF_CLK_IN),
    .SRST_IN    (SRST_IN),
    .d_in       (FL_DQ_IN),
    .q_out      (dq_sync)
  );

  // Forces address bits for the special pin modes
  function [AW-1:0] mode_addr;
    input [`FWP_CMD_W-1:0] op;
    input [AW-1:0]         a;
    reg   [AW-1:0]         r;
    begin
      r = a;
      if (op == `FWP_CMD_VERIFY) begin
        r[`FWP_ABIT1] = 1'b1;
        r[`FWP_ABIT0] = 1'b0;
        r[`FWP_ABIT6] = 1'b0;
      end else if (op == `FWP_CMD_UNPROTECT) begin
        r[`FWP_ABIT6] = 1'b1;
      end
      mode_addr = r;
    end
  endfunction

  // Unprotect only after a protect command has completed since reset or the last unprotect
  wire unprot_refused = (CMD_CODE_IN == `FWP_CMD_UNPROTECT) && !all_prot_r;
  assign CMD_READY_OUT = (state_r == ST_IDLE) && !SRST_IN;
  wire take = CMD_VALID_IN && CMD_READY_OUT && (CMD_CODE_IN != `FWP_CMD_NOP);

  // ****************************************
  // Sequencer
  // ****************************************
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (take && !unprot_refused &&
            CMD_CODE_IN != `FWP_CMD_TEMP_ON && CMD_CODE_IN != `FWP_CMD_TEMP_OFF) begin
          state_nxt = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (cnt_r == 8'h00) begin
          if (op_r == `FWP_CMD_READ || op_r == `FWP_CMD_VERIFY) begin
            state_nxt = ST_READ;
          end else begin
            state_nxt = ST_PULSE;
          end
        end
      end
      ST_PULSE: begin
        if (cnt_r == 8'h00) begin
          state_nxt = ST_HOLD;
        end
      end
      ST_READ: begin
        if (cnt_r == 8'h00) begin
          state_nxt = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (cnt_r == 8'h00) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      state_r         <= ST_IDLE;
      cnt_r           <= 8'h00;
      op_r            <= `FWP_CMD_NOP;
      all_prot_r      <= 1'b0;
      RSP_VALID_OUT   <= 1'b0;
      RSP_DATA_OUT    <= {DW{1'b0}};
      RSP_PROT_OUT    <= 1'b0;
      TEMP_UNPROT_OUT <= 1'b0;
      CMD_REFUSED_OUT <= 1'b0;
      FL_CE_N_OUT     <= 1'b1;
      FL_OE_N_OUT     <= 1'b1;
      FL_WE_N_OUT     <= 1'b1;
      FL_ADDR_OUT     <= {AW{1'b0}};
      FL_DQ_OUT       <= {DW{1'b0}};
      FL_DQ_OE_N_OUT  <= 1'b1;
      FL_HV_RESET_OUT <= 1'b0;
      FL_HV_OE_OUT    <= 1'b0;
      FL_HV_A9_OUT    <= 1'b0;
    end else begin
      state_r         <= state_nxt;
      RSP_VALID_OUT   <= 1'b0;
      CMD_REFUSED_OUT <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (take) begin
            op_r <= CMD_CODE_IN;
            if (CMD_CODE_IN == `FWP_CMD_TEMP_ON) begin
              FL_HV_RESET_OUT <= 1'b1;
              TEMP_UNPROT_OUT <= 1'b1;
              RSP_VALID_OUT   <= 1'b1;
            end else if (CMD_CODE_IN == `FWP_CMD_TEMP_OFF) begin
              FL_HV_RESET_OUT <= 1'b0;
              TEMP_UNPROT_OUT <= 1'b0;
              RSP_VALID_OUT   <= 1'b1;
            end else if (unprot_refused) begin
              CMD_REFUSED_OUT <= 1'b1;
              RSP_VALID_OUT   <= 1'b1;
            end else begin
              cnt_r       <= SETUP_CYC - 8'h01;
              FL_ADDR_OUT <= mode_addr(CMD_CODE_IN, CMD_ADDR_IN);
              FL_CE_N_OUT <= 1'b0;
              if (CMD_CODE_IN == `FWP_CMD_WRITE) begin
                FL_DQ_OUT      <= CMD_DATA_IN;
                FL_DQ_OE_N_OUT <= 1'b0;
              end
              if (CMD_CODE_IN == `FWP_CMD_PROTECT ||
                  CMD_CODE_IN == `FWP_CMD_UNPROTECT) begin
                FL_HV_A9_OUT <= 1'b1;
                FL_HV_OE_OUT <= 1'b1;
              end
              if (CMD_CODE_IN == `FWP_CMD_VERIFY) begin
                FL_HV_A9_OUT <= 1'b1;
              end
            end
          end
        end
        ST_SETUP: begin
          cnt_r <= cnt_r - 8'h01;
          if (cnt_r == 8'h00) begin
            if (op_r == `FWP_CMD_READ || op_r == `FWP_CMD_VERIFY) begin
              FL_OE_N_OUT <= 1'b0;
              cnt_r       <= READ_CYC - 8'h01;
            end else begin
              // OE stays high so the write is not inhibited
              FL_WE_N_OUT <= 1'b0;
              cnt_r       <= PULSE_CYC - 8'h01;
            end
          end
        end
        ST_PULSE: begin
          cnt_r <= cnt_r - 8'h01;
          if (cnt_r == 8'h00) begin
            FL_WE_N_OUT <= 1'b1;
            cnt_r       <= SETUP_CYC - 8'h01;
          end
        end
        ST_READ: begin
          cnt_r <= cnt_r - 8'h01;
          if (cnt_r == 8'h00) begin
            RSP_DATA_OUT <= dq_sync;
            RSP_PROT_OUT <= dq_sync[`FWP_PROT_BIT];
            FL_OE_N_OUT  <= 1'b1;
            cnt_r        <= SETUP_CYC - 8'h01;
          end
        end
        ST_HOLD: begin
          cnt_r <= cnt_r - 8'h01;
          if (cnt_r == 8'h00) begin
            FL_CE_N_OUT    <= 1'b1;
            FL_DQ_OE_N_OUT <= 1'b1;
            FL_HV_A9_OUT   <= 1'b0;
            FL_HV_OE_OUT   <= 1'b0;
            RSP_VALID_OUT  <= 1'b1;
            if (op_r == `FWP_CMD_PROTECT) begin
              all_prot_r <= 1'b1;
            end
            if (op_r == `FWP_CMD_UNPROTECT) begin
              all_prot_r <= 1'b0;
            end
          end
        end
        default: cnt_r <= 8'h00;
      endcase
    end
  end
endmodule // fwp_host

// File: test/fwp_flash_model.sv
// Behavioural flash seen from its pins, with sector protection
`timescale 1ns/10ps
module fwp_flash_model #(
  parameter [7:0] ID_CODE = 8'h3c // Arbitrary identification value
) (
  input  wire        ce_n_in,
  input  wire        oe_n_in,
  input  wire        we_n_in,
  input  wire        hv_rst_in,
  input  wire        hv_oe_in,
  input  wire        hv_a9_in,
  input  wire [19:0] a_in,
  input  wire [7:0]  d_in,
  output wire [7:0]  q_out
);
  reg  [15:0] prot_r = 16'h0000;
  reg  [7:0]  mem_r [0:15];
  reg  [7:0]  last_r = 8'h00;
  time        fall_t = 0;
  wire [3:0]  sect   = a_in[19:16];
  wire        rd_en  = !ce_n_in && !oe_n_in;
  wire [7:0]  rd_val = hv_a9_in ? (a_in[1] ? {7'h00, prot_r[sect]} : ID_CODE)
                                : mem_r[sect];
  always @(negedge we_n_in) begin
    fall_t = $time;
  end
  always @(posedge we_n_in) begin
    if (!ce_n_in && $time - fall_t >= 5) begin
      if (hv_a9_in && hv_oe_in) begin
        if (a_in[6]) begin
          prot_r <= 16'h0000;
        end else begin
          prot_r[sect] <= 1'b1;
        end
      end else if (oe_n_in && (!prot_r[sect] || hv_rst_in)) begin
        mem_r[sect] <= d_in;
      end
    end
  end
  // Byte last driven, kept for the released bus
  always @(posedge oe_n_in) begin
    last_r <= rd_val;
  end
  // Released bus shows the inverse of the last byte
  assign q_out = rd_en ? rd_val : ~last_r;
endmodule // fwp_flash_model

// File: test/fwp_host_monitor.sv
// Assertion checker bound to the flash protection host
`timescale 1ns/10ps
module fwp_host_monitor #(
  parameter AW = 20
) (
  input wire          REF_CLK_IN,
  input wire          SRST_IN,
  input wire          CMD_VALID_IN,
  input wire [2:0]    CMD_CODE_IN,
  input wire          CMD_READY_OUT,
  input wire          RSP_VALID_OUT,
  input wire          TEMP_UNPROT_OUT,
  input wire          CMD_REFUSED_OUT,
  input wire          FL_CE_N_OUT,
  input wire          FL_OE_N_OUT,
  input wire          FL_WE_N_OUT,
  input wire [AW-1:0] FL_ADDR_OUT,
  input wire          FL_HV_RESET_OUT,
  input wire          FL_HV_OE_OUT,
  input wire          FL_HV_A9_OUT
);
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (SRST_IN);
  wire take = CMD_VALID_IN && CMD_READY_OUT;
  a_reset_quiet: assert property (disable iff (1'b0) SRST_IN |=>
    FL_CE_N_OUT && FL_WE_N_OUT && !FL_HV_A9_OUT && !FL_HV_OE_OUT && !FL_HV_RESET_OUT)
    else $error("strobes active after reset");
  a_write_inhibit: assert property (!FL_WE_N_OUT |-> FL_OE_N_OUT && !FL_CE_N_OUT)
    else $error("write strobe with bad enables");
  a_we_width: assert property ($fell(FL_WE_N_OUT) |-> ##25 $rose(FL_WE_N_OUT))
    else $error("write pulse width wrong");
  a_long_latency: assert property (take && CMD_CODE_IN inside {3'h1, 3'h2, 3'h3, 3'h4}
    |-> ##46 RSP_VALID_OUT) else $error("completion late or early");
  a_hv_protect: assert property ($fell(FL_WE_N_OUT) && FL_HV_OE_OUT
    |-> FL_HV_A9_OUT && !FL_CE_N_OUT) else $error("protect pulse without bit 9 level");
  a_hv_held: assert property ($rose(FL_WE_N_OUT) && $past(FL_HV_OE_OUT) |-> FL_HV_OE_OUT)
    else $error("high voltage dropped inside pulse");
  a_verify_pins: assert property (!FL_OE_N_OUT && FL_HV_A9_OUT |-> FL_WE_N_OUT
    && FL_ADDR_OUT[1] && !FL_ADDR_OUT[0] && !FL_ADDR_OUT[6]) else $error("verify pins wrong");
  a_refuse_idle: assert property (CMD_REFUSED_OUT |-> RSP_VALID_OUT && FL_CE_N_OUT
    && !FL_HV_OE_OUT) else $error("refusal with pin activity");
  a_temp_on: assert property (take && CMD_CODE_IN == 3'h6 |=> ##[0:1]
    FL_HV_RESET_OUT && TEMP_UNPROT_OUT) else $error("reset level not applied");
  a_temp_off: assert property (take && CMD_CODE_IN == 3'h7 |=> ##[0:1] !FL_HV_RESET_OUT)
    else $error("reset level not removed");
  c_write: cover property ($rose(FL_WE_N_OUT) && !FL_HV_OE_OUT);
  c_protect: cover property ($rose(FL_WE_N_OUT) && FL_HV_OE_OUT);
  c_refuse: cover property (CMD_REFUSED_OUT);
endmodule // fwp_host_monitor
bind fwp_host fwp_host_monitor #(.AW(AW)) u_mon (
  .REF_CLK_IN      (REF_CLK_IN),
  .SRST_IN         (SRST_IN),
  .CMD_VALID_IN    (CMD_VALID_IN),
  .CMD_CODE_IN     (CMD_CODE_IN),
  .CMD_READY_OUT   (CMD_READY_OUT),
  .RSP_VALID_OUT   (RSP_VALID_OUT),
  .TEMP_UNPROT_OUT (TEMP_UNPROT_OUT),
  .CMD_REFUSED_OUT (CMD_REFUSED_OUT),
  .FL_CE_N_OUT     (FL_CE_N_OUT),
  .FL_OE_N_OUT     (FL_OE_N_OUT),
  .FL_WE_N_OUT     (FL_WE_N_OUT),
  .FL_ADDR_OUT     (FL_ADDR_OUT),
  .FL_HV_RESET_OUT (FL_HV_RESET_OUT),
  .FL_HV_OE_OUT    (FL_HV_OE_OUT),
  .FL_HV_A9_OUT    (FL_HV_A9_OUT)
);

// File: test/fwp_host_tb.sv
// Self-checking bench for the flash protection host
`timescale 1ns/10ps
module fwp_host_tb;
  reg         clk = 1'b0, srst = 1'b1, valid = 1'b0;
  reg  [2:0]  code = 3'h0;
  reg  [19:0] addr = 20'h0;
  reg  [7:0]  data = 8'h0, got;
  reg         refused;
  integer     err_count = 0, tests_run = 0;
  wire        rdy, rv, rp, tu, rf, ce_n, oe_n, we_n, dq_oe_n, hv_r, hv_oe, hv_a9;
  wire [19:0] fa;
  wire [7:0]  rd, dq, fq;
  always #2 clk = ~clk;
  fwp_host u_dut (.REF_CLK_IN(clk), .SRST_IN(srst), .CMD_VALID_IN(valid), .CMD_CODE_IN(code),
    .CMD_ADDR_IN(addr), .CMD_DATA_IN(data), .CMD_READY_OUT(rdy), .RSP_VALID_OUT(rv),
    .RSP_DATA_OUT(rd), .RSP_PROT_OUT(rp), .TEMP_UNPROT_OUT(tu), .CMD_REFUSED_OUT(rf),
    .FL_CE_N_OUT(ce_n), .FL_OE_N_OUT(oe_n), .FL_WE_N_OUT(we_n), .FL_ADDR_OUT(fa),
    .FL_DQ_OUT(dq), .FL_DQ_OE_N_OUT(dq_oe_n), .FL_DQ_IN(dq_oe_n ? fq : dq),
    .FL_HV_RESET_OUT(hv_r), .FL_HV_OE_OUT(hv_oe), .FL_HV_A9_OUT(hv_a9));
  fwp_flash_model u_flash (.ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n), .hv_rst_in(hv_r),
    .hv_oe_in(hv_oe), .hv_a9_in(hv_a9), .a_in(fa), .d_in(dq), .q_out(fq));
  task chk(input [7:0] g, input [7:0] e);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("wrong value at %0t ns: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task cmd(input [2:0] c, input [19:0] a, input [7:0] d);
    integer n;
    begin
      @(negedge clk);
      valid = 1'b1;
      code  = c;
      addr  = a;
      data  = d;
      n     = 0;
      while (rdy !== 1'b1 && n < 100) begin
        @(negedge clk);
        n = n + 1;
      end
      @(negedge clk);
      valid = 1'b0;
      while (rv !== 1'b1 && n < 200) begin
        @(negedge clk);
        n = n + 1;
      end
      chk({7'h00, rv}, 8'h01);
      got     = rd;
      refused = rf;
    end
  endtask
  task rd8(input [2:0] c, input [19:0] a, input [7:0] e);
    begin
      cmd(c, a, 8'h00);
      chk(got, e);
    end
  endtask
  task t_rw;
    begin
      cmd(3'h1, 20'h20000, 8'ha5);
      cmd(3'h1, 20'h50000, 8'h3c);
      rd8(3'h2, 20'h20000, 8'ha5);
      $display("write and read done");
    end
  endtask
  task t_prot;
    begin
      cmd(3'h3, 20'h20000, 8'h00);
      rd8(3'h4, 20'h20002, 8'h01);
      chk({7'h00, rp}, 8'h01);
      rd8(3'h4, 20'h50002, 8'h00);
      cmd(3'h1, 20'h20000, 8'h5a);
      rd8(3'h2, 20'h20000, 8'ha5);
      $display("sector protect done");
    end
  endtask
  task t_temp;
    begin
      cmd(3'h6, 20'h00000, 8'h00);
      chk({7'h00, tu}, 8'h01);
      cmd(3'h1, 20'h20000, 8'h66);
      rd8(3'h2, 20'h20000, 8'h66);
      cmd(3'h7, 20'h00000, 8'h00);
      chk({7'h00, tu}, 8'h00);
      cmd(3'h1, 20'h20000, 8'h77);
      rd8(3'h2, 20'h20000, 8'h66);
      $display("temporary unprotect done");
    end
  endtask
  task t_unprot;
    begin
      cmd(3'h3, 20'h50000, 8'h00);
      cmd(3'h5, 20'h00040, 8'h00);
      chk({7'h00, refused}, 8'h00);
      rd8(3'h4, 20'h20002, 8'h00);
      rd8(3'h4, 20'h50002, 8'h00);
      cmd(3'h1, 20'h20000, 8'h88);
      rd8(3'h2, 20'h20000, 8'h88);
      cmd(3'h5, 20'h00040, 8'h00);
      chk({7'h00, refused}, 8'h01);
      $display("chip unprotect done");
    end
  endtask
  // Idle code, then a reset in mid-run with the reset level applied
  task t_reset;
    begin
      cmd(3'h3, 20'h20000, 8'h00);
      cmd(3'h6, 20'h00000, 8'h00);
      @(negedge clk);
      valid = 1'b1;
      code  = 3'h0;
      @(negedge clk);
      chk({6'h00, rv, rdy}, 8'h01);
      valid = 1'b0;
      srst  = 1'b1;
      repeat (2) @(negedge clk);
      chk({5'h00, rdy, tu, hv_r}, 8'h00);
      chk({5'h00, ce_n, we_n, dq_oe_n}, 8'h07);
      srst = 1'b0;
      cmd(3'h5, 20'h00040, 8'h00);
      chk({7'h00, refused}, 8'h01);
      $display("reset and idle code done");
    end
  endtask
  task report_and_stop;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
        $display("All tests passed");
      end else begin
        $display("Some tests failed");
      end
      $finish;
    end
  endtask
  initial begin
    repeat (10) @(negedge clk);
    srst = 1'b0;
    t_rw;
    t_prot;
    t_temp;
    t_unprot;
    t_reset;
    report_and_stop;
  end
  // Watchdog at about ten times the expected run
  initial begin
    #40000;
    err_count = err_count + 1;
    report_and_stop;
  end
endmodule // fwp_host_tb
